// ==== hw/pfs_supervisor.sv ====
// protection and sequencing supervisor of a point-of-load converter
// assumes samples and configuration are synchronous to clk
`timescale 1ns/10ps
module pfs_supervisor import pfs_pkg::*; #(
  parameter int MS_CYCLES = MS_CYC,
  parameter int OT_CYCLES = OT_DLY_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pfs_cfg_s cfg,
  input wire logic enable_req,
  input wire logic fault_clear,
  input wire logic [15:0] vout_mv,
  input wire logic vout_valid,
  input wire logic signed [7:0] temp_c,
  input wire logic temp_valid,
  output logic conv_on,
  output logic [15:0] ref_mv,
  output logic output_good_flag,
  output logic ot_warn_flag,
  output pfs_stat_s stat
);
  // ========================================================
  // held samples
  logic [15:0] vout_r;
  logic [15:0] vout_nxt;
  logic signed [7:0] temp_r;
  logic signed [7:0] temp_nxt;
  logic ot_hot_r;
  logic ot_hot_nxt;
  logic warn_raw_r;
  logic warn_raw_nxt;

  always_comb begin
    vout_nxt = vout_r;
    temp_nxt = temp_r;
    ot_hot_nxt = ot_hot_r;
    warn_raw_nxt = warn_raw_r;
    if (vout_valid) begin
      vout_nxt = vout_mv;
    end
    if (temp_valid) begin
      temp_nxt = temp_c;
    end
    if (temp_r >= OT_OFF_C) begin
      ot_hot_nxt = 1'b1;
    end else if (temp_r <= OT_ON_C) begin
      ot_hot_nxt = 1'b0;
    end
    if (temp_r >= WARN_SET_C) begin
      warn_raw_nxt = 1'b1;
    end else if (temp_r <= WARN_CLR_C) begin
      warn_raw_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vout_r <= 16'h0000;
      temp_r <= 8'sh00;
      ot_hot_r <= 1'b0;
      warn_raw_r <= 1'b0;
    end else begin
      vout_r <= vout_nxt;
      temp_r <= temp_nxt;
      ot_hot_r <= ot_hot_nxt;
      warn_raw_r <= warn_raw_nxt;
    end
  end

  // ========================================================
  // limits from setpoint
  pfs_state_e state_r;
  pfs_state_e state_nxt;
  logic [15:0] ref_r;
  logic [15:0] ref_nxt;
  logic [7:0] uv_pct;
  logic [7:0] ov_pct;
  logic [15:0] uv_lim;
  logic [15:0] ov_lim;
  logic [15:0] ov_raw_lim;
  logic [15:0] pg_lo;
  logic [15:0] pg_hi;
  logic [15:0] trk_dev;
  logic [4:0] raw;
  logic [4:0] flt;
  logic ot_flt;

  always_comb begin
    uv_pct = UV_BASE_PCT + UV_STEP_PCT * {6'h00, cfg.uv_sel};
    ov_pct = OV_BASE_PCT + OV_STEP_PCT * {6'h00, cfg.ov_sel};
    if (ov_pct > OV_MAX_PCT) begin
      ov_pct = OV_MAX_PCT;
    end
    uv_lim = pfs_pct(cfg.setpoint_mv, uv_pct);
    ov_raw_lim = pfs_pct(cfg.setpoint_mv, ov_pct);
    // a tiny setpoint would put the trip inside the noise
    ov_lim = (ov_raw_lim < OV_FLOOR_MV) ? OV_FLOOR_MV : ov_raw_lim;
    pg_lo = pfs_pct(cfg.setpoint_mv,
                    cfg.pg_sel ? PG_LO_ALT_PCT : PG_LO_PCT);
    pg_hi = pfs_pct(cfg.setpoint_mv, PG_HI_PCT);
    trk_dev = (vout_r > ref_r) ? vout_r - ref_r : ref_r - vout_r;
    raw[0] = (state_r == S_ON) && (vout_r < uv_lim);
    raw[1] = (state_r != S_OFF) && (state_r != S_FLT)
             && (vout_r > ov_lim);
    raw[2] = cfg.trk_en && (state_r == S_RUP)
             && (trk_dev > TRK_DEV_MV);
    raw[3] = (vout_r >= pg_lo) && (vout_r <= pg_hi);
    raw[4] = warn_raw_r;
  end

  // one 6 us filter per undervoltage, overvoltage and tracking fault, window and warning input
  generate
    for (genvar i = 0; i < 5; i++) begin : g_filt
      pfs_hold_filter #(.N(PROT_DLY_CYC)) u_filt (
        .clk(clk),
        .rst_n(rst_n),
        .din(raw[i]),
        .dout(flt[i])
      );
    end
  endgenerate

  pfs_hold_filter #(.N(OT_CYCLES)) u_ot_filt (
    .clk(clk),
    .rst_n(rst_n),
    .din(ot_hot_r),
    .dout(ot_flt)
  );

  assign output_good_flag = flt[3];
  assign ot_warn_flag = flt[4];

  // ========================================================
  // tick generators
  logic [16:0] ms_cnt_r;
  logic [16:0] ms_cnt_nxt;
  logic [9:0] rt_cnt_r;
  logic [9:0] rt_cnt_nxt;
  logic ms_tick;
  logic rt_tick;

  always_comb begin
    ms_tick = (ms_cnt_r == 17'(MS_CYCLES - 1));
    rt_tick = (rt_cnt_r == 10'(RAMP_TICK_CYC - 1));
    ms_cnt_nxt = ms_tick ? 17'h00000 : ms_cnt_r + 17'h00001;
    rt_cnt_nxt = rt_tick ? 10'h000 : rt_cnt_r + 10'h001;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 17'h00000;
      rt_cnt_r <= 10'h000;
    end else begin
      ms_cnt_r <= ms_cnt_nxt;
      rt_cnt_r <= rt_cnt_nxt;
    end
  end

  // ========================================================
  // sequencer and fault handling
  logic [7:0] dly_r;
  logic [7:0] dly_nxt;
  logic on_r;
  logic on_nxt;
  logic lat_r;
  logic lat_nxt;
  pfs_stat_s stat_r;
  pfs_stat_s stat_nxt;
  logic [16:0] up_sum;
  logic [15:0] up_step;
  logic [15:0] dn_step;
  logic active;
  logic new_uv;
  logic new_ov;
  logic new_ot;
  logic new_trk;
  logic any_new;

  always_comb begin
    state_nxt = state_r;
    ref_nxt = ref_r;
    dly_nxt = dly_r;
    on_nxt = on_r;
    lat_nxt = lat_r;
    stat_nxt = stat_r;
    up_step = {9'h000, pfs_slew(cfg.rise_sel)};
    dn_step = {9'h000, pfs_slew(cfg.fall_sel)};
    up_sum = {1'b0, ref_r} + {1'b0, up_step};
    active = (state_r == S_RUP) || (state_r == S_ON)
             || (state_r == S_TOFF) || (state_r == S_RDN);
    // act only while the cause persists: filters lag their recovery
    new_uv = active && flt[0] && raw[0];
    new_ov = active && flt[1] && raw[1];
    new_ot = active && ot_flt && ot_hot_r;
    new_trk = active && flt[2] && raw[2];
    any_new = new_uv || new_ov || new_ot || new_trk;
    if (fault_clear) begin
      stat_nxt = '0;
    end
    // a fault in the clearing cycle still sets its flag
    stat_nxt.uv = stat_nxt.uv | new_uv;
    stat_nxt.ov = stat_nxt.ov | new_ov;
    stat_nxt.ot = stat_nxt.ot | new_ot;
    stat_nxt.trk = stat_nxt.trk | new_trk;
    if (ms_tick && dly_r != 8'hFF) begin
      dly_nxt = dly_r + 8'h01;
    end
    if (any_new) begin
      state_nxt = S_FLT;
      on_nxt = 1'b0;
      ref_nxt = REF_RST;
      dly_nxt = 8'h00;
      lat_nxt = (new_uv && cfg.uv_latch) || (new_ov && cfg.ov_latch)
                || (new_ot && cfg.ot_latch)
                || (new_trk && cfg.trk_latch);
    end else begin
      case (state_r)
        S_OFF: begin
          if (enable_req && !ot_hot_r) begin
            state_nxt = S_TON;
            dly_nxt = 8'h00;
          end
        end
        S_TON: begin
          if (!enable_req) begin
            state_nxt = S_OFF;
          end else if (dly_r >= cfg.ton_ms) begin
            state_nxt = S_RUP;
            on_nxt = 1'b1;
            ref_nxt = REF_RST;
          end
        end
        S_RUP: begin
          if (!enable_req) begin
            state_nxt = S_TOFF;
            dly_nxt = 8'h00;
          end else if (rt_tick) begin
            if (up_sum >= {1'b0, cfg.setpoint_mv}) begin
              ref_nxt = cfg.setpoint_mv;
              state_nxt = S_ON;
            end else begin
              ref_nxt = up_sum[15:0];
            end
          end
        end
        S_ON: begin
          ref_nxt = cfg.setpoint_mv;
          if (!enable_req) begin
            state_nxt = S_TOFF;
            dly_nxt = 8'h00;
          end
        end
        S_TOFF: begin
          if (dly_r >= {2'h0, cfg.toff_ms}) begin
            state_nxt = S_RDN;
          end
        end
        S_RDN: begin
          if (rt_tick) begin
            if (ref_r <= dn_step) begin
              ref_nxt = REF_RST;
              on_nxt = 1'b0;
              state_nxt = S_OFF;
            end else begin
              ref_nxt = ref_r - dn_step;
            end
          end
        end
        S_FLT: begin
          if (fault_clear) begin
            state_nxt = S_OFF;
            lat_nxt = 1'b0;
          end else if (!lat_r && dly_r >= RETRY_MS && !ot_hot_r) begin
            state_nxt = S_OFF;
          end
        end
        default: begin
          state_nxt = S_OFF;
          on_nxt = 1'b0;
          ref_nxt = REF_RST;
        end
      endcase
    end
    stat_nxt.latched = lat_nxt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_OFF;
      ref_r <= REF_RST;
      dly_r <= 8'h00;
      on_r <= 1'b0;
      lat_r <= 1'b0;
      stat_r <= '0;
    end else begin
      state_r <= state_nxt;
      ref_r <= ref_nxt;
      dly_r <= dly_nxt;
      on_r <= on_nxt;
      lat_r <= lat_nxt;
      stat_r <= stat_nxt;
    end
  end

  assign conv_on = on_r;
  assign ref_mv = ref_r;
  assign stat = stat_r;

  // ========================================================
  // checks
  logic [16:0] hot_cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hot_cnt_r <= 17'h00000;
    end else if (!ot_hot_r) begin
      hot_cnt_r <= 17'h00000;
    end else if (hot_cnt_r != 17'h1FFFF) begin
      hot_cnt_r <= hot_cnt_r + 17'h00001;
    end
  end

  property p_uv_range;
    @(posedge clk) disable iff (!rst_n)
      uv_pct >= UV_BASE_PCT && uv_pct <= 8'h5A;
  endproperty
  a_uv_range: assert property (p_uv_range)
    else $error("undervoltage percentage out of range");

  property p_uv_off;
    @(posedge clk) disable iff (!rst_n)
      (flt[0] && raw[0]) |=> !on_r && state_r == S_FLT;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("undervoltage did not turn converter off");

  property p_ov_floor;
    @(posedge clk) disable iff (!rst_n)
      (cfg.setpoint_mv < 16'h0300) |-> ov_lim == OV_FLOOR_MV;
  endproperty
  a_ov_floor: assert property (p_ov_floor)
    else $error("overvoltage limit below floor");

  property p_ot_block;
    @(posedge clk) disable iff (!rst_n)
      (state_r == S_OFF && ot_hot_r) |=> state_r == S_OFF;
  endproperty
  a_ot_block: assert property (p_ot_block)
    else $error("started while still hot");

  property p_ot_dly;
    @(posedge clk) disable iff (!rst_n)
      $rose(ot_flt) |-> hot_cnt_r >= 17'(OT_CYCLES - 1);
  endproperty
  a_ot_dly: assert property (p_ot_dly)
    else $error("overtemp fault before its delay");

  property p_trk_off;
    @(posedge clk) disable iff (!rst_n)
      !cfg.trk_en |-> !raw[2];
  endproperty
  a_trk_off: assert property (p_trk_off)
    else $error("tracking check while disabled");

  property p_trk_ramp;
    @(posedge clk) disable iff (!rst_n)
      raw[2] |-> state_r == S_RUP && on_r;
  endproperty
  a_trk_ramp: assert property (p_trk_ramp)
    else $error("tracking check outside ramp up");

  property p_warn_hys;
    @(posedge clk) disable iff (!rst_n)
      (warn_raw_r && temp_r > WARN_CLR_C) |=> warn_raw_r;
  endproperty
  a_warn_hys: assert property (p_warn_hys)
    else $error("warning cleared inside hysteresis");

  property p_pg_out;
    @(posedge clk) disable iff (!rst_n)
      (vout_r > pg_hi || vout_r < pg_lo) |-> !raw[3];
  endproperty
  a_pg_out: assert property (p_pg_out)
    else $error("good window accepts out of window voltage");

  property p_ramp_cap;
    @(posedge clk) disable iff (!rst_n)
      (state_r == S_RUP) |-> ref_r <= cfg.setpoint_mv;
  endproperty
  a_ramp_cap: assert property (p_ramp_cap)
    else $error("ramp reference above setpoint");

  property p_retry_wait;
    @(posedge clk) disable iff (!rst_n)
      (state_r == S_FLT && !lat_r && dly_r < RETRY_MS && !fault_clear)
        |=> state_r == S_FLT && !on_r;
  endproperty
  a_retry_wait: assert property (p_retry_wait)
    else $error("retry before its period");

  property p_latch_hold;
    @(posedge clk) disable iff (!rst_n)
      (state_r == S_FLT && lat_r && !fault_clear) |=> state_r == S_FLT;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched fault released without clear");
endmodule

// ==== pkg/pfs_pkg.sv ====
// constants, types and helpers of the point-of-load fault supervisor
// assumes one 50 MHz clock and samples already in the clock domain
// ==========================================================
// Overview of operation
// - undervoltage trip 75..90 percent, 5 percent steps
// - undervoltage turn-off about 6 us after crossing
// - overvoltage trip never below 1.0 volt
// - overtemp off at 120 C, restart at 110
// - overtemp turn-off about 2 ms after threshold
// - tracking off after reset, latching or retry
// - tracking off 6 us after 250 mV deviation
// - overtemp warning at 120 C, 3 C hysteresis
// - warning asserts about 6 us after threshold
// - good flag high inside window, low outside
// - good window 110 top, 90 or 95 bottom
// - good flag changes about 6 us after crossing
// - on delay 0..255 ms, off 0..63 ms
// - rise and fall slew seven settings each
// - non-latching faults retry every 130 ms
package pfs_pkg;
  // ========================================================
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  localparam int PROT_DLY_NS = 6000;
  localparam int PROT_DLY_CYC = PROT_DLY_NS * CYC_PER_US / 1000;
  localparam int OT_DLY_MS = 2;
  localparam int OT_DLY_CYC = OT_DLY_MS * (CLK_HZ / 1000);
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int RAMP_TICK_US = 10;
  localparam int RAMP_TICK_CYC = RAMP_TICK_US * CYC_PER_US;
  localparam logic [7:0] RETRY_MS = 8'h82;
  // ========================================================
  // thresholds, percent of setpoint, mV and degrees C
  localparam logic [7:0] UV_BASE_PCT = 8'h4B;
  localparam logic [7:0] UV_STEP_PCT = 8'h05;
  localparam logic [7:0] OV_BASE_PCT = 8'h6E;
  localparam logic [7:0] OV_STEP_PCT = 8'h0A;
  localparam logic [7:0] OV_MAX_PCT = 8'h82;
  localparam logic [15:0] OV_FLOOR_MV = 16'h03E8;
  localparam logic [7:0] PG_LO_PCT = 8'h5A;
  localparam logic [7:0] PG_LO_ALT_PCT = 8'h5F;
  localparam logic [7:0] PG_HI_PCT = 8'h6E;
  localparam logic signed [7:0] OT_OFF_C = 8'sh78;
  localparam logic signed [7:0] OT_ON_C = 8'sh6E;
  localparam logic signed [7:0] WARN_SET_C = 8'sh78;
  localparam logic signed [7:0] WARN_CLR_C = 8'sh75;
  localparam logic [15:0] TRK_DEV_MV = 16'h00FA;
  // default encodings software should load after reset
  localparam logic [1:0] UV_SEL_RST = 2'h0;
  localparam logic [1:0] OV_SEL_RST = 2'h2;
  localparam logic PG_SEL_RST = 1'b0;
  localparam logic [2:0] SLEW_SEL_RST = 3'h0;
  localparam logic [15:0] REF_RST = 16'h0000;
  // ========================================================
  // types
  typedef enum logic [6:0] {
    S_OFF = 7'h01,
    S_TON = 7'h02,
    S_RUP = 7'h04,
    S_ON = 7'h08,
    S_TOFF = 7'h10,
    S_RDN = 7'h20,
    S_FLT = 7'h40
  } pfs_state_e;
  typedef struct packed {
    logic [15:0] setpoint_mv;
    logic [1:0] uv_sel;
    logic [1:0] ov_sel;
    logic pg_sel;
    logic uv_latch;
    logic ov_latch;
    logic ot_latch;
    logic trk_en;
    logic trk_latch;
    logic [7:0] ton_ms;
    logic [5:0] toff_ms;
    logic [2:0] rise_sel;
    logic [2:0] fall_sel;
  } pfs_cfg_s;
  typedef struct packed {
    logic uv;
    logic ov;
    logic ot;
    logic trk;
    logic latched;
  } pfs_stat_s;
  // ========================================================
  // helpers
  function automatic logic [15:0] pfs_pct(input logic [15:0] v,
                                          input logic [7:0] p);
    logic [23:0] prod;
    logic [23:0] quo;
    prod = v * p;
    quo = prod / 24'h000064;
    return quo[15:0];
  endfunction
  // ramp step in mV per 10 us: 0.1 .. 8.3 V/ms
  function automatic logic [6:0] pfs_slew(input logic [2:0] sel);
    case (sel)
      3'h0: return 7'h01;
      3'h1: return 7'h02;
      3'h2: return 7'h05;
      3'h3: return 7'h0A;
      3'h4: return 7'h14;
      3'h5: return 7'h32;
      default: return 7'h53;
    endcase
  endfunction
endpackage

// ==== hw/pfs_hold_filter.sv ====
// hold filter: output follows input once it has differed n cycles
// assumes input is synchronous to clk
`timescale 1ns/10ps
module pfs_hold_filter import pfs_pkg::*; #(
  parameter int N = PROT_DLY_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic [16:0] cnt_r;
  logic [16:0] cnt_nxt;
  logic dout_r;
  logic dout_nxt;

  // a glitch shorter than n cycles restarts the count
  always_comb begin
    cnt_nxt = 17'h00000;
    dout_nxt = dout_r;
    if (din != dout_r) begin
      if (cnt_r >= 17'(N - 1)) begin
        dout_nxt = din;
      end else begin
        cnt_nxt = cnt_r + 17'h00001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 17'h00000;
      dout_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      dout_r <= dout_nxt;
    end
  end

  assign dout = dout_r;

  property p_hold_follow;
    @(posedge clk) disable iff (!rst_n)
      $changed(dout_r) |-> ($past(din) == dout_r)
                           && $past(cnt_r) == 17'(N - 1);
  endproperty
  a_hold_follow: assert property (p_hold_follow)
    else $error("filter output changed without settled input");

  property p_hold_still;
    @(posedge clk) disable iff (!rst_n)
      (din == dout_r) |=> $stable(dout_r) && cnt_r == 17'h00000;
  endproperty
  a_hold_still: assert property (p_hold_still)
    else $error("filter output moved while input matched");
endmodule

// ==== tb/pfs_plant.sv ====
// power stage and measurement converter model for the supervisor bench
// assumes the bench drives the offset, forcing and temperature controls
`timescale 1ns/10ps
module pfs_plant (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_on,
  input wire logic [15:0] ref_mv,
  input wire logic [15:0] dev_mv,
  input wire logic force_en,
  input wire logic [15:0] force_mv,
  input wire logic signed [7:0] temp_set,
  output logic [15:0] vout_mv,
  output logic vout_valid,
  output logic signed [7:0] temp_c,
  output logic temp_valid
);
  logic [2:0] cnt_r;
  // ==========================================================
  // converters deliver one sample of each kind every 8 clocks
  // unless forced to force_mv, output is 0 V while stopped, it follows the reference plus offset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      vout_mv <= 16'h0000;
      vout_valid <= 1'b0;
      temp_c <= 8'sh00;
      temp_valid <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      vout_valid <= (cnt_r == 3'h0);
      temp_valid <= (cnt_r == 3'h4);
      if (cnt_r == 3'h0) begin
        vout_mv <= force_en ? force_mv
                   : (conv_on ? ref_mv + dev_mv : 16'h0000);
      end
      if (cnt_r == 3'h4) begin
        temp_c <= temp_set;
      end
    end
  end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the point-of-load fault supervisor
// assumes the plant model answers with periodic samples
`timescale 1ns/10ps
module testbench;
  import pfs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pfs_cfg_s cfg;
  logic enable_req = 1'b0;
  logic fault_clear = 1'b0;
  logic [15:0] vout_mv;
  logic vout_valid;
  logic signed [7:0] temp_c;
  logic temp_valid;
  logic conv_on;
  logic [15:0] ref_mv;
  logic output_good_flag;
  logic ot_warn_flag;
  pfs_stat_s stat;
  logic [15:0] dev_mv = 16'h0000;
  logic force_en = 1'b0;
  logic [15:0] force_mv = 16'h0000;
  logic signed [7:0] temp_set = 8'sh19;
  int fail_count = 0;
  int total_checks = 0;
  // ==========================================================
  // clock, design and plant
  always #10 clk = ~clk;
  // short ms tick keeps the 130 ms retry waits affordable
  pfs_supervisor #(.MS_CYCLES(50), .OT_CYCLES(200)) dut (
    .clk(clk), .rst_n(rst_n), .cfg(cfg), .enable_req(enable_req),
    .fault_clear(fault_clear), .vout_mv(vout_mv), .vout_valid(vout_valid),
    .temp_c(temp_c), .temp_valid(temp_valid), .conv_on(conv_on),
    .ref_mv(ref_mv), .output_good_flag(output_good_flag),
    .ot_warn_flag(ot_warn_flag), .stat(stat));
  pfs_plant plant (
    .clk(clk), .rst_n(rst_n), .conv_on(conv_on), .ref_mv(ref_mv),
    .dev_mv(dev_mv), .force_en(force_en), .force_mv(force_mv),
    .temp_set(temp_set), .vout_mv(vout_mv), .vout_valid(vout_valid),
    .temp_c(temp_c), .temp_valid(temp_valid));
  // ==========================================================
  // shared tasks
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return conv_on;
      1: return output_good_flag;
      default: return ot_warn_flag;
    endcase
  endfunction
  // old level still seen after lo cycles, new level reached by lo+hi
  task automatic dly(input int s, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    cyc(lo);
    chk(sig(s), !v);
    while (sig(s) !== v && n < hi) begin
      cyc(1);
      n++;
    end
    chk(sig(s), v);
  endtask
  task automatic wait_ref();
    int n;
    n = 0;
    while (ref_mv !== cfg.setpoint_mv && n < 8000) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic clear_pulse();
    fault_clear = 1'b1;
    cyc(1);
    fault_clear = 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_seq();
    int n;
    n = 0;
    chk(stat, 16'h0000);
    chk(ref_mv, 16'h0000);
    dev_mv = 16'h010E;
    enable_req = 1'b1;
    dly(0, 1'b1, 90, 80);
    while (ref_mv === 16'h0000 && n < 600) begin
      cyc(1);
      n++;
    end
    chk(ref_mv, 16'h0053);
    wait_ref();
    chk(ref_mv, 16'h03E8);
    chk(stat, 16'h0000);
    dev_mv = 16'h0000;
    dly(1, 1'b1, 250, 80);
  endtask
  task automatic t_pg();
    force_en = 1'b1;
    force_mv = 16'h03C0;
    cyc(400);
    chk(output_good_flag, 1'b1);
    force_mv = 16'h03AC;
    dly(1, 1'b0, 250, 80);
    force_mv = 16'h03E8;
    dly(1, 1'b1, 250, 80);
    force_mv = 16'h0456;
    dly(1, 1'b0, 250, 80);
  endtask
  task automatic t_uv_retry();
    cfg.uv_sel = 2'h3;
    force_mv = 16'h0352;
    dly(0, 1'b0, 280, 50);
    chk(stat.uv, 1'b1);
    chk(stat.latched, 1'b0);
    force_en = 1'b0;
    dly(0, 1'b1, 6400, 400);
    wait_ref();
  endtask
  task automatic t_uv_latch();
    cfg.uv_latch = 1'b1;
    force_en = 1'b1;
    force_mv = 16'h0352;
    dly(0, 1'b0, 280, 50);
    force_en = 1'b0;
    cyc(7000);
    chk(conv_on, 1'b0);
    chk(stat.latched, 1'b1);
    // reconfigured while held off by the latched fault
    cfg.setpoint_mv = 16'h02EE;
    cfg.uv_sel = 2'h0;
    cfg.uv_latch = 1'b0;
    cfg.ov_sel = 2'h0;
    cfg.ov_latch = 1'b1;
    clear_pulse();
    chk(stat, 16'h0000);
    dly(0, 1'b1, 1, 300);
    wait_ref();
  endtask
  task automatic t_ov();
    force_en = 1'b1;
    force_mv = 16'h03B6;
    cyc(400);
    chk(conv_on, 1'b1);
    chk(stat.ov, 1'b0);
    force_mv = 16'h041A;
    dly(0, 1'b0, 280, 50);
    chk(stat.ov, 1'b1);
    force_en = 1'b0;
  endtask
  task automatic t_trk();
    cfg.setpoint_mv = 16'h03E8;
    cfg.ov_sel = 2'h2;
    cfg.ov_latch = 1'b0;
    cfg.trk_en = 1'b1;
    cfg.trk_latch = 1'b1;
    // offset stays above the limit even right after a ramp step
    dev_mv = 16'h0190;
    clear_pulse();
    dly(0, 1'b1, 1, 300);
    dly(0, 1'b0, 280, 50);
    chk(stat, 16'h0003);
    dev_mv = 16'h0000;
    cfg.trk_en = 1'b0;
    clear_pulse();
    dly(0, 1'b1, 1, 300);
    wait_ref();
  endtask
  task automatic t_ot();
    temp_set = 8'sh7D;
    dly(0, 1'b0, 180, 50);
    chk(stat.ot, 1'b1);
    dly(2, 1'b1, 50, 80);
    temp_set = 8'sh76;
    cyc(400);
    chk(ot_warn_flag, 1'b1);
    temp_set = 8'sh73;
    dly(2, 1'b0, 280, 50);
    cyc(7000);
    chk(conv_on, 1'b0);
    temp_set = 8'sh69;
    dly(0, 1'b1, 1, 500);
    cyc(300);
    chk(conv_on, 1'b1);
  endtask
  task automatic t_off();
    int n;
    n = 0;
    wait_ref();
    cfg.toff_ms = 6'h02;
    enable_req = 1'b0;
    cyc(90);
    chk(conv_on, 1'b1);
    chk(ref_mv, 16'h03E8);
    while (ref_mv === 16'h03E8 && n < 600) begin
      cyc(1);
      n++;
    end
    chk(ref_mv, 16'h0395);
    dly(0, 1'b0, 5900, 200);
    chk(ref_mv, 16'h0000);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    cfg = '0;
    cfg.setpoint_mv = 16'h03E8;
    cfg.ov_sel = 2'h2;
    cfg.pg_sel = 1'b1;
    cfg.ton_ms = 8'h02;
    cfg.rise_sel = 3'h6;
    cfg.fall_sel = 3'h6;
    cyc(2);
    rst_n = 1'b1;
    t_seq();
    t_pg();
    t_uv_retry();
    t_uv_latch();
    t_ov();
    t_trk();
    t_ot();
    t_off();
    end_of_test();
  end
  // run needs about 63000 cycles, the limit leaves ample margin
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule
